/* rtl/bsc_pkg.sv */
// Shared constants and types of the burst SRAM control block
package bsc_pkg;

  // Array shape: 32K words of 32 data bits plus byte parity
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 32;
  localparam int PAR_W      = 4;
  localparam int WORD_W     = DATA_W + PAR_W;
  localparam int STEP_W     = 2;
  localparam int FIFO_DEPTH = 32;

  // Avalon register window, byte addresses
  localparam int AV_ADDR_W  = 4;
  localparam int AV_DATA_W  = 32;
  localparam logic [AV_ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h4;

  // Control register fields
  localparam int CTRL_LINEAR_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // Status register fields
  localparam int STAT_STEP_LSB   = 0;
  localparam int STAT_ACTIVE_BIT = 2;
  localparam int STAT_FULL_BIT   = 3;
  localparam int STAT_EMPTY_BIT  = 4;
  localparam int STAT_WRITE_BIT  = 5;

  // Pin group as seen by the synchroniser
  typedef struct packed {
    logic              cpuStb_n;
    logic              ctrlStb_n;
    logic              chipSel_n;
    logic              adv_n;
    logic              wrEn_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } bsc_pin_t;

  // One posted write waiting for the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } bsc_wr_t;

  typedef enum logic [0:0] {BSC_IDLE, BSC_BURST} bsc_mode_t;

endpackage : bsc_pkg

/* rtl/bsc_fifo.sv */
// Synchronous FIFO with registered read data for posted writes
`timescale 1ns/1ps
`default_nettype none
module bsc_fifo #(
  parameter int WIDTH = 51,
  parameter int DEPTH = 32
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  // Level flags
  output logic                  full,
  output logic                  empty
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg, rdPtr_reg;
  logic [PTR_W:0]   count_reg;
  logic             outValid_reg;
  logic [WIDTH-1:0] outData_reg;
  logic             push, pop, load;

  // Output stage refills whenever it is empty or being taken
  assign full     = (count_reg == DEPTH_C);
  assign empty    = (count_reg == '0) && !outValid_reg;
  assign inReady  = !full;
  assign push     = inValid && inReady;
  assign load     = (count_reg != '0) && (!outValid_reg || outReady);
  assign pop      = load;
  assign outValid = outValid_reg;
  assign outData  = outData_reg;

  // Storage, read data always leave through a register
  always_ff @(posedge clk) begin
    if (ce) begin
      if (push) begin
        mem[wrPtr_reg] <= inData;
      end
      if (load) begin
        outData_reg <= mem[rdPtr_reg];
      end
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      count_reg    <= '0;
      outValid_reg <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      if (load) begin
        outValid_reg <= 1'b1;
      end else if (outReady) begin
        outValid_reg <= 1'b0;
      end
    end
  end

endmodule // bsc_fifo
`default_nettype wire

/* rtl/bsc_burst_sram.sv */
// Burst SRAM control: strobes, 2-bit burst counter, array, Avalon regs
//
// Notes on behaviour
// - Strobe at clock edge captures base address
// - Counter makes the three following burst addresses
// - Two-bit counter, interleaved or linear variant
// - Counter advances only when advance is asserted
// - Wait states keep counter; burst resumes unchanged
// - Either address strobe starts burst, loads base
// - Output enable asynchronous, gates data drivers
// - Output enable never touches the burst counter
// - Array is 32K words of 32 bits
// - Four transfers per line, optional byte parity
// - Zero-wait line fill takes five clocks; here the first word follows the strobe by four clocks
// - Writes posted, completed by self-timed engine
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bsc_burst_sram #(
  parameter int FIFO_DEPTH_P = bsc_pkg::FIFO_DEPTH
) (
  // Clock, reset, clock enable
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // Host control pins
  input  wire logic                          cpuAddrStrobe_n,
  input  wire logic                          ctrlAddrStrobe_n,
  input  wire logic                          chipSel_n,
  input  wire logic                          burstAdvance_n,
  input  wire logic                          writeEnable_n,
  input  wire logic                          outEnable_n,
  input  wire logic [bsc_pkg::ADDR_W-1:0]    addrIn,
  // Host data bus, split into in, out and enable
  input  wire logic [bsc_pkg::WORD_W-1:0]    dataIn,
  output logic [bsc_pkg::WORD_W-1:0]         dataOut,
  output logic                               dataOe,
  output logic                               writeReady,
  // Avalon-MM slave
  input  wire logic [bsc_pkg::AV_ADDR_W-1:0] avAddress,
  input  wire logic                          avRead,
  input  wire logic                          avWrite,
  input  wire logic [bsc_pkg::AV_DATA_W-1:0] avWriteData,
  input  wire logic [3:0]                    avByteEnable,
  output logic [bsc_pkg::AV_DATA_W-1:0]      avReadData,
  output logic                               avWaitRequest
);
  import bsc_pkg::*;

  // Register state of this module apart from the array and arrayRd_reg
  typedef struct packed {
    bsc_pin_t          sync1;
    bsc_pin_t          sync2;
    bsc_mode_t         mode;
    logic [ADDR_W-1:0] base;
    logic [STEP_W-1:0] step;
    logic [1:0]        ctrl;
    logic              avAck;
    logic [AV_DATA_W-1:0] avRdData;
    logic              rdPending;
    logic              readDue;
  } bsc_state_t;

  bsc_state_t st_reg, st_next;

  // Array with registered read data
  logic [WORD_W-1:0] array [2**ADDR_W];
  logic [WORD_W-1:0] arrayRd_reg;
  logic [ADDR_W-1:0] arrayAddr;
  logic              arrayWe;
  logic              arrayRe;

  // Posted write path
  bsc_wr_t           pushWord;
  bsc_wr_t           drainWord;
  logic              pushValid;
  logic              drainValid;
  logic              drainReady;
  logic              fifoFull;
  logic              fifoEmpty;

  // Decoded pin view, read only from the second flop stage
  logic              strobeHit;
  logic              advance;
  logic              writeCycle;
  logic              readCycle;
  logic [ADDR_W-1:0] burstAddr;
  logic              linearMode;
  logic              enabled;
  logic              avAccess;
  logic              avHit;
  logic [AV_DATA_W-1:0] statusWord;

  // Low burst bits: XOR for interleaved, add for linear; the upper
  // bits are never touched, so the count wraps inside its line
  function automatic logic [ADDR_W-1:0] bsc_burst_addr(
    input logic [ADDR_W-1:0] base,
    input logic [STEP_W-1:0] step,
    input logic              linear
  );
    logic [STEP_W-1:0] low;
    low = linear ? STEP_W'(base[STEP_W-1:0] + step)
                 : (base[STEP_W-1:0] ^ step);
    return {base[ADDR_W-1:STEP_W], low};
  endfunction

  // Merge an Avalon write into a field under its byte enables
  function automatic logic [AV_DATA_W-1:0] bsc_merge(
    input logic [AV_DATA_W-1:0] old,
    input logic [AV_DATA_W-1:0] wdata,
    input logic [3:0]           be
  );
    logic [AV_DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pin decode; a strobe without chip select is not for us
  assign linearMode = st_reg.ctrl[CTRL_LINEAR_BIT];
  assign enabled    = st_reg.ctrl[CTRL_ENABLE_BIT];
  assign strobeHit  = enabled && !st_reg.sync2.chipSel_n
                   && (!st_reg.sync2.cpuStb_n
                    || !st_reg.sync2.ctrlStb_n);
  assign advance    = !st_reg.sync2.adv_n && !strobeHit;
  assign burstAddr  = bsc_burst_addr(st_reg.base, st_reg.step,
                                     linearMode);
  // The strobe cycle itself carries no write: base and step are
  // still those of the old line, so a write there would land wrong
  assign writeCycle = (st_reg.mode == BSC_BURST) && !strobeHit
                   && !st_reg.sync2.wrEn_n;
  assign readCycle  = (st_reg.mode == BSC_BURST) && st_reg.readDue
                   && st_reg.sync2.wrEn_n;

  // Writes are posted: the captured word goes to the FIFO and the
  // array is written later, so no host write pulse is timed here
  assign pushValid       = writeCycle;
  assign pushWord.addr   = burstAddr;
  assign pushWord.data   = st_reg.sync2.data;

  // Reads own the array port only right after base or step moved;
  // every other cycle is free for the drain, so posted writes land
  assign drainReady = !readCycle;
  assign arrayWe    = drainValid && drainReady;
  assign arrayRe    = readCycle;
  assign arrayAddr  = arrayWe ? drainWord.addr : burstAddr;
  assign writeReady = !fifoFull;

  // Data drivers follow output enable without the clock; nothing
  // clocked reads it, so toggling it cannot disturb the burst
  assign dataOe  = !outEnable_n;
  assign dataOut = arrayRd_reg;

  // Avalon: one wait cycle on every access, answer on the next edge
  assign avAccess      = avRead || avWrite;
  assign avWaitRequest = avAccess && !st_reg.avAck;
  assign avReadData    = st_reg.avRdData;
  assign avHit         = (avAddress == REG_CTRL)
                      || (avAddress == REG_STATUS);

  // Status word shows the live burst state and posted-write level
  always_comb begin
    statusWord = '0;
    statusWord[STAT_STEP_LSB +: STEP_W] = st_reg.step;
    statusWord[STAT_ACTIVE_BIT] = (st_reg.mode == BSC_BURST);
    statusWord[STAT_FULL_BIT]   = fifoFull;
    statusWord[STAT_EMPTY_BIT]  = fifoEmpty;
    statusWord[STAT_WRITE_BIT]  = st_reg.rdPending;
  end

  // Next state of all registers held in st_reg
  always_comb begin
    logic [AV_DATA_W-1:0] ctrlWide;
    ctrlWide = '0;
    st_next  = st_reg;

    // Pins other than outEnable_n pass two flops before anything looks at them
    st_next.sync1.cpuStb_n  = cpuAddrStrobe_n;
    st_next.sync1.ctrlStb_n = ctrlAddrStrobe_n;
    st_next.sync1.chipSel_n = chipSel_n;
    st_next.sync1.adv_n     = burstAdvance_n;
    st_next.sync1.wrEn_n    = writeEnable_n;
    st_next.sync1.addr      = addrIn;
    st_next.sync1.data      = dataIn;
    st_next.sync2           = st_reg.sync1;

    // A fresh strobe always wins; this is how the host abandons a
    // line fill and starts another one
    if (strobeHit) begin
      st_next.mode = BSC_BURST;
      st_next.base = st_reg.sync2.addr;
      st_next.step = '0;
    end else if (!enabled) begin
      st_next.mode = BSC_IDLE;
    end else if ((st_reg.mode == BSC_BURST) && advance) begin
      // Two-bit count wraps on its own after the fourth word
      st_next.step = st_reg.step + 1'b1;
    end
    // With advance deasserted nothing changes: the wait state keeps the
    // counter, and the next advance continues the same sequence

    // Write flag shows the last burst cycle carried a write
    st_next.rdPending = writeCycle;

    // Re-read the array only when base or step has just moved; a
    // burst that sits idle must not starve the write drain
    st_next.readDue = strobeHit
                   || (enabled && (st_reg.mode == BSC_BURST) && advance);

    // Avalon handshake and register access
    st_next.avAck = avAccess && !st_reg.avAck;
    if (avRead && !st_reg.avAck) begin
      if (avAddress == REG_CTRL) begin
        st_next.avRdData = AV_DATA_W'(st_reg.ctrl);
      end else if (avAddress == REG_STATUS) begin
        st_next.avRdData = statusWord;
      end else begin
        st_next.avRdData = '0;                 // Unmapped reads zero
      end
    end
    if (avWrite && st_reg.avAck && avHit
        && (avAddress == REG_CTRL)) begin
      ctrlWide    = bsc_merge(AV_DATA_W'(st_reg.ctrl), avWriteData,
                              avByteEnable);
      st_next.ctrl = ctrlWide[1:0];
    end
  end

  // Register the whole state; the enable freezes every flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.sync1    <= '1;
      st_reg.sync2    <= '1;
      st_reg.mode     <= BSC_IDLE;
      st_reg.ctrl     <= CTRL_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Array: 32K words, one port, read data registered so that the
  // first word leaves a fixed number of clocks after the strobe
  always_ff @(posedge clk) begin
    if (ce) begin
      if (arrayWe) begin
        array[arrayAddr] <= drainWord.data;
      end else if (arrayRe) begin
        arrayRd_reg <= array[arrayAddr];
      end
    end
  end

  // Posted-write buffer between the input registers and the array
  bsc_fifo #(
    .WIDTH ($bits(bsc_wr_t)),
    .DEPTH (FIFO_DEPTH_P)
  ) u_wr_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .inValid  (pushValid),
    .inReady  (),
    .inData   (pushWord),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainWord),
    .full     (fifoFull),
    .empty    (fifoEmpty)
  );

endmodule // bsc_burst_sram
`default_nettype wire

/* verif/bsc_burst_sram_monitor.sv */
// Port-level assertions for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module bsc_burst_sram_monitor (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rst_n,
  // Host pins
  input wire logic                          cpuAddrStrobe_n,
  input wire logic                          ctrlAddrStrobe_n,
  input wire logic                          chipSel_n,
  input wire logic                          burstAdvance_n,
  input wire logic                          writeEnable_n,
  input wire logic                          outEnable_n,
  input wire logic [bsc_pkg::WORD_W-1:0]    dataOut,
  input wire logic                          dataOe,
  // Avalon slave
  input wire logic [bsc_pkg::AV_ADDR_W-1:0] avAddress,
  input wire logic                          avRead,
  input wire logic                          avWrite,
  input wire logic [bsc_pkg::AV_DATA_W-1:0] avReadData,
  input wire logic                          avWaitRequest
);
  import bsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet_reg, quiet_next;
  logic       rdStart, avAck;
  // Selected read strobe, and a read that is being answered
  assign rdStart = !(cpuAddrStrobe_n && ctrlAddrStrobe_n) && !chipSel_n
                   && writeEnable_n;
  assign avAck = avRead && !avWaitRequest;
  // Quiet counter: idle until the first read burst, so unknown data is skipped
  always_comb begin
    quiet_next = quiet_reg;
    if (rdStart || (quiet_reg != 3'h0 && !burstAdvance_n)) quiet_next = 3'h1;
    else if (quiet_reg != 3'h0 && quiet_reg != 3'h7)
      quiet_next = quiet_reg + 3'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) quiet_reg <= 3'h0;
    else quiet_reg <= quiet_next;
  end
  sequence s_oneWait;
    avWaitRequest ##1 !avWaitRequest;
  endsequence
  property p_wait_once;
    $rose(avRead || avWrite) |-> s_oneWait;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("waitrequest not exactly one cycle");
  property p_unmapped;
    avAck && avAddress != REG_CTRL && avAddress != REG_STATUS
      |-> avReadData == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ctrl_bits;
    avAck && avAddress == REG_CTRL |-> avReadData[AV_DATA_W-1:2] == '0;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits)
    else $error("control spare bits set");
  property p_status_bits;
    avAck && avAddress == REG_STATUS |-> avReadData[AV_DATA_W-1:6] == '0
      && !(avReadData[STAT_FULL_BIT] && avReadData[STAT_EMPTY_BIT]);
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status bits inconsistent");
  property p_rd_hold;
    !avAck |-> $stable(avReadData);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("readdata moved without a read");
  property p_oe_follow;
    dataOe == !outEnable_n;
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("data drive does not follow output enable");
  property p_oe_edge;
    $fell(outEnable_n) |-> $rose(dataOe);
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data drive late after output enable");
  property p_quiet_hold;
    quiet_reg == 3'h7 |-> $stable(dataOut);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold)
    else $error("read data moved without strobe or advance");
endmodule // bsc_burst_sram_monitor
bind bsc_burst_sram bsc_burst_sram_monitor bsc_burst_sram_monitor_inst (
  .clk              (clk),
  .rst_n            (rst_n),
  .cpuAddrStrobe_n  (cpuAddrStrobe_n),
  .ctrlAddrStrobe_n (ctrlAddrStrobe_n),
  .chipSel_n        (chipSel_n),
  .burstAdvance_n   (burstAdvance_n),
  .writeEnable_n    (writeEnable_n),
  .outEnable_n      (outEnable_n),
  .dataOut          (dataOut),
  .dataOe           (dataOe),
  .avAddress        (avAddress),
  .avRead           (avRead),
  .avWrite          (avWrite),
  .avReadData       (avReadData),
  .avWaitRequest    (avWaitRequest)
);
`default_nettype wire

/* verif/bsc_host_model.sv */
// Host-side model: cache controller driving strobes, advance and data
`timescale 1ns/1ps
`default_nettype none
module bsc_host_model (
  // Clock and returned data
  input wire logic                       clk,
  input wire logic [bsc_pkg::WORD_W-1:0] dataOut,
  // Host control pins
  output logic                           cpuAddrStrobe_n,
  output logic                           ctrlAddrStrobe_n,
  output logic                           chipSel_n,
  output logic                           burstAdvance_n,
  output logic                           writeEnable_n,
  output logic                           outEnable_n,
  output logic [bsc_pkg::ADDR_W-1:0]     addrIn,
  output logic [bsc_pkg::WORD_W-1:0]     dataIn
);
  import bsc_pkg::*;
  logic [WORD_W-1:0] got [4];
  logic [WORD_W-1:0] seen [12];
  // Idle pins at time zero
  initial begin
    {cpuAddrStrobe_n, ctrlAddrStrobe_n, chipSel_n} <= 3'h7;
    {burstAdvance_n, writeEnable_n, outEnable_n} <= 3'h6;
    addrIn <= '0;
    dataIn <= '0;
  end
  // Word stored at each address: parity nibble plus address both ways
  function automatic logic [WORD_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {4'hA, 2'h0, ~a, a};
  endfunction
  // One line: gap 0 runs back to back, else waits with the bus floated
  task automatic burst(input logic ctl, sel, wr,
                       input logic [ADDR_W-1:0] a, input int gap);
    int i;
    // A fresh strobe is how the host drops or starts a line fill
    cpuAddrStrobe_n <= ctl;
    ctrlAddrStrobe_n <= !ctl;
    chipSel_n <= !sel;
    writeEnable_n <= !wr;
    addrIn <= a;
    dataIn <= pat(a);
    @(posedge clk);
    {cpuAddrStrobe_n, ctrlAddrStrobe_n, chipSel_n} <= 3'h7;
    addrIn <= ~a; // Address no longer qualified, so show a wrong one
    if (gap == 0) begin
      // Write word k stands in the cycle after k advances; bases aligned
      for (i = 1; i < 12; i++) begin
        burstAdvance_n <= !(i < 4 && sel);
        writeEnable_n <= !(wr && i < 5);
        dataIn <= pat({a[ADDR_W-1:2], 2'(i - 1)});
        @(posedge clk);
        seen[i] = dataOut;
      end
    end else begin
      for (i = 0; i < 4; i++) begin
        outEnable_n <= 1'b1;
        repeat (gap) @(posedge clk);
        outEnable_n <= 1'b0;
        @(posedge clk);
        got[i] = dataOut;
        burstAdvance_n <= !(i < 3 && sel);
        @(posedge clk);
        burstAdvance_n <= 1'b1;
      end
    end
    writeEnable_n <= 1'b1;
    @(posedge clk); // Idle edge so the next call never reassigns a pin
  endtask
endmodule // bsc_host_model
`default_nettype wire

/* verif/bsc_burst_sram_tb_top.sv */
// Self-checking testbench of the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module bsc_burst_sram_tb_top;
  import bsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce, cpuAddrStrobe_n, ctrlAddrStrobe_n, chipSel_n, burstAdvance_n;
  logic writeEnable_n, outEnable_n, dataOe, writeReady;
  logic [ADDR_W-1:0] addrIn;
  logic [WORD_W-1:0] dataIn, dataOut;
  logic [AV_ADDR_W-1:0] avAddress;
  logic avRead, avWrite, avWaitRequest;
  logic [AV_DATA_W-1:0] avWriteData, avReadData, rd;
  logic [3:0] avByteEnable;
  int errTotal = 0;
  int nChecks = 0;
  int k, i0;
  // 125 MHz clock
  always #4 clk = ~clk;
  bsc_burst_sram bsc_burst_sram_inst (
    .clk              (clk),
    .rst_n            (rst_n),
    .ce               (ce),
    .cpuAddrStrobe_n  (cpuAddrStrobe_n),
    .ctrlAddrStrobe_n (ctrlAddrStrobe_n),
    .chipSel_n        (chipSel_n),
    .burstAdvance_n   (burstAdvance_n),
    .writeEnable_n    (writeEnable_n),
    .outEnable_n      (outEnable_n),
    .addrIn           (addrIn),
    .dataIn           (dataIn),
    .dataOut          (dataOut),
    .dataOe           (dataOe),
    .writeReady       (writeReady),
    .avAddress        (avAddress),
    .avRead           (avRead),
    .avWrite          (avWrite),
    .avWriteData      (avWriteData),
    .avByteEnable     (avByteEnable),
    .avReadData       (avReadData),
    .avWaitRequest    (avWaitRequest)
  );
  bsc_host_model host (
    .clk              (clk),
    .dataOut          (dataOut),
    .cpuAddrStrobe_n  (cpuAddrStrobe_n),
    .ctrlAddrStrobe_n (ctrlAddrStrobe_n),
    .chipSel_n        (chipSel_n),
    .burstAdvance_n   (burstAdvance_n),
    .writeEnable_n    (writeEnable_n),
    .outEnable_n      (outEnable_n),
    .addrIn           (addrIn),
    .dataIn           (dataIn)
  );
  // Compare and count
  task automatic chk(input string nm, input logic [WORD_W-1:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic avXfer(input logic wr, input logic [AV_ADDR_W-1:0] a,
                        input logic [AV_DATA_W-1:0] wd);
    avAddress <= a;
    avWriteData <= wd;
    avWrite <= wr;
    avRead <= !wr;
    @(posedge clk);
    while (avWaitRequest !== 1'b0) @(posedge clk);
    rd = avReadData;
    avRead <= 1'b0;
    avWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic endOfTest;
    $display("Checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    endOfTest();
  end
  // Main sequence
  initial begin
    ce <= 1'b1;
    {avAddress, avRead, avWrite, avWriteData} <= '0;
    avByteEnable <= 4'hF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    avXfer(1'b0, REG_CTRL, '0);
    chk("ctrl reset", WORD_W'(rd), WORD_W'(32'h2));
    avXfer(1'b1, 4'h8, 32'hFFFF_FFFF);
    avXfer(1'b0, 4'h8, '0);
    chk("unmapped", WORD_W'(rd), '0);
    avXfer(1'b0, REG_STATUS, '0);
    chk("status reset", WORD_W'(rd), WORD_W'(32'h10));
    // Fill two lines, one at the top of the array to catch carries
    host.burst(1'b0, 1'b1, 1'b1, 15'h0120, 0);
    host.burst(1'b1, 1'b1, 1'b1, 15'h7FFC, 0);
    repeat (60) @(posedge clk);
    // Posted writes must have drained: FIFO empty, line left at step 3
    chk("write ready", WORD_W'(writeReady), WORD_W'(1));
    avXfer(1'b0, REG_STATUS, '0);
    chk("drained", WORD_W'(rd), WORD_W'(32'h17));
    // Interleaved read with waits, controller strobe
    host.burst(1'b1, 1'b1, 1'b0, 15'h7FFE, 6);
    for (k = 0; k < 4; k++)
      chk("ilv", host.got[k], host.pat({13'h1FFF, 2'(k) ^ 2'h2}));
    avXfer(1'b1, REG_CTRL, 32'h3);
    avXfer(1'b0, REG_CTRL, '0);
    chk("ctrl linear", WORD_W'(rd), WORD_W'(32'h3));
    // Linear read with waits, processor strobe
    host.burst(1'b0, 1'b1, 1'b0, 15'h0121, 6);
    for (k = 0; k < 4; k++)
      chk("lin", host.got[k], host.pat({13'h0048, 2'(k + 1)}));
    // Zero-wait line: one word on each following clock
    host.burst(1'b0, 1'b1, 1'b0, 15'h0123, 0);
    i0 = 0;
    for (k = 7; k > 0; k--)
      if (host.seen[k] === host.pat(15'h0123)) i0 = k;
    // Two sync flops, the capture edge and the read register
    chk("first word", WORD_W'(i0), WORD_W'(4));
    for (k = 1; k < 4; k++)
      chk("zero wait", host.seen[i0 + k],
          host.pat({13'h0048, 2'(k + 3)}));
    // Strobe without chip select leaves the line untouched
    host.burst(1'b1, 1'b0, 1'b0, 15'h7FFC, 6);
    chk("no select", host.got[3], host.pat(15'h0122));
    endOfTest();
  end
endmodule // bsc_burst_sram_tb_top
`default_nettype wire
